// file: atf_map.svh
// constants for the transport framer: characters, sizes and counts
`ifndef ATF_MAP_SVH
`define ATF_MAP_SVH
`define ATF_COMMA      8'hbc
`define ATF_SYNC_A     8'h47
`define ATF_SYNC_B     8'hb8
`define ATF_SIZE_A     8'hbc
`define ATF_SIZE_B     8'hcc
`define ATF_TWIN_CNT   2'h2
`define ATF_TX_AW      4
`define ATF_RX_AW      4
`endif

// file: atf_pkg.sv
// types shared by the transport framer files
`default_nettype none
package atf_pkg;
    typedef struct packed {
        logic       k;
        logic [7:0] data;
    } atf_sym_t;

    typedef struct packed {
        logic       locked;
        logic [7:0] syncByte;
        logic [7:0] pktSize;
    } atf_rx_status_t;

    typedef enum logic [1:0] {
        ATF_SEEK,
        ATF_TRACK,
        ATF_LOCKED
    } atf_hunt_t;
endpackage : atf_pkg
`default_nettype wire

// file: atf_fifo.sv
// word fifo with registered read data and registered full flag
`timescale 1ns/10ps
`default_nettype none
module atf_fifo #(
    parameter int WIDTH = 9,
    parameter int AW    = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic             rdEn,
    output logic      [WIDTH-1:0] rdData,
    output logic                  rdValid,
    output logic                  full,
    output logic                  empty
);
    localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

    logic [WIDTH-1:0] mem [0:(1<<AW)-1];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             doWr;
    logic             doRd;

    // writes into a full fifo and reads from an empty one are dropped
    assign doWr  = wrEn && !full;
    assign doRd  = rdEn && !empty;
    assign empty = (count_reg == '0);

    // occupancy after this cycle
    always_comb begin
        count_next = count_reg;
        if (doWr && !doRd) begin
            count_next = count_reg + 1'b1;
        end else if (doRd && !doWr) begin
            count_next = count_reg - 1'b1;
        end
    end

    // storage array
    always_ff @(posedge core_clk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= wrData;
        end
    end

    // pointers, count and full flag
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            full      <= 1'b0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            count_reg <= count_next;
            full      <= (count_next == DEPTH);
        end
    end

    // read data register, valid one cycle after an accepted read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData  <= '0;
            rdValid <= 1'b0;
        end else begin
            rdValid <= doRd;
            if (doRd) begin
                rdData <= mem[rdPtr_reg];
            end
        end
    end
endmodule : atf_fifo
`default_nettype wire

// file: asi_transport_framer.sv
// transport framer: comma insertion on transmit, comma removal and sync hunt on receive
`timescale 1ns/10ps
`default_nettype none
`include "atf_map.svh"
module asi_transport_framer
    import atf_pkg::*;
#(
    parameter int TX_AW = `ATF_TX_AW,
    parameter int RX_AW = `ATF_RX_AW
) (
    input  wire logic           core_clk,
    input  wire logic           rst,
    input  wire logic [7:0]     txDin,
    input  wire logic           txPsync,
    input  wire logic           txDvalid,
    output var  atf_sym_t       txWord,
    output logic                txFifoFull,
    input  wire atf_sym_t       rxWord,
    output logic [7:0]          rxDout,
    output logic                rxDvalid,
    output logic                rxPsync,
    output logic                rxFifoFull,
    input  wire logic [7:0]     lockThr,
    input  wire logic [7:0]     unlockThr,
    input  wire logic [7:0]     huntThr,
    output var  atf_rx_status_t rxStatus,
    output logic                rxRunt,
    output logic                rxGiant
);
    // candidate sync byte: even index 47h, odd index B8h
    function automatic logic [7:0] candSync(input logic [1:0] idx);
        candSync = idx[0] ? `ATF_SYNC_B : `ATF_SYNC_A;
    endfunction : candSync

    // candidate packet size: low pair 188, high pair 204
    function automatic logic [7:0] candSize(input logic [1:0] idx);
        candSize = idx[1] ? `ATF_SIZE_B : `ATF_SIZE_A;
    endfunction : candSize

    // ---------------- transmit ----------------
    logic       txRdEn;
    logic [8:0] txRdData;
    logic       txRdValid;
    logic       txEmpty;
    logic       txFull;
    logic [7:0] holdData_reg;
    logic       holdValid_reg;
    logic [1:0] preCnt_reg;
    logic       rdPend_reg;
    logic       sendWord;

    atf_fifo #(.WIDTH(9), .AW(TX_AW)) txFifo (
        .core_clk (core_clk),
        .rst      (rst),
        // only valid words written, dropped when full
        .wrEn     (txDvalid),
        .wrData   ({txPsync, txDin}),
        .rdEn     (txRdEn),
        .rdData   (txRdData),
        .rdValid  (txRdValid),
        .full     (txFull),
        .empty    (txEmpty)
    );

    // the held word leaves this cycle once its leading commas are out
    assign sendWord = holdValid_reg && (preCnt_reg == 2'h0);
    // fetch only when the hold register will be free for the answer
    assign txRdEn   = !txEmpty && !rdPend_reg && (!holdValid_reg || sendWord);

    // hold register and leading comma count
    // reset clears all state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            holdData_reg  <= 8'h00;
            holdValid_reg <= 1'b0;
            preCnt_reg    <= 2'h0;
            rdPend_reg    <= 1'b0;
        end else begin
            rdPend_reg <= txRdEn;
            if (txRdValid) begin
                holdData_reg  <= txRdData[7:0];
                holdValid_reg <= 1'b1;
                // twin commas only from the start flag
                preCnt_reg    <= txRdData[8] ? `ATF_TWIN_CNT : 2'h0;
            end else if (sendWord) begin
                holdValid_reg <= 1'b0;
            end else if (holdValid_reg) begin
                preCnt_reg <= preCnt_reg - 2'h1;
            end
        end
    end

    // symbol output register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            txWord     <= '{k: 1'b1, data: `ATF_COMMA};
            txFifoFull <= 1'b0;
        end else begin
            txFifoFull <= txFull;
            if (sendWord) begin
                txWord <= '{k: 1'b0, data: holdData_reg};
            end else begin
                // comma fill or lead, marked as control
                txWord <= '{k: 1'b1, data: `ATF_COMMA};
            end
        end
    end

    // ---------------- receive ----------------
    logic       rxRdValid;
    logic [7:0] rxRdData;
    logic       rxEmpty;
    logic       rxFull;
    atf_hunt_t  hunt_reg;
    logic [1:0] candIdx_reg;
    logic [7:0] pos_reg;
    logic [7:0] matchCnt_reg;
    logic [7:0] errCnt_reg;
    logic [7:0] huntCnt_reg;
    logic [8:0] since_reg;
    logic [7:0] curSync;
    logic [7:0] curSize;
    logic       isSync;
    logic       atBound;

    atf_fifo #(.WIDTH(8), .AW(RX_AW)) rxFifo (
        .core_clk (core_clk),
        .rst      (rst),
        .wrEn     (!rxWord.k),
        .wrData   (rxWord.data),
        .rdEn     (1'b1),
        .rdData   (rxRdData),
        .rdValid  (rxRdValid),
        .full     (rxFull),
        .empty    (rxEmpty)
    );

    assign curSync = candSync(candIdx_reg);
    assign curSize = candSize(candIdx_reg);
    assign isSync  = (rxRdData == curSync);
    assign atBound = (hunt_reg != ATF_SEEK) && (pos_reg == curSize);

    // sync hunt, lock tracking and candidate stepping
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hunt_reg     <= ATF_SEEK;
            candIdx_reg  <= 2'h0;
            pos_reg      <= 8'h00;
            matchCnt_reg <= 8'h00;
            errCnt_reg   <= 8'h00;
            huntCnt_reg  <= 8'h00;
        end else if (rxRdValid) begin
            pos_reg <= pos_reg + 8'h01;
            case (hunt_reg)
                ATF_SEEK: begin
                    if (isSync) begin
                        hunt_reg     <= ATF_TRACK;
                        pos_reg      <= 8'h01;
                        matchCnt_reg <= 8'h00;
                    end
                end
                ATF_TRACK: begin
                    if (atBound) begin
                        pos_reg <= 8'h01;
                        if (9'(huntCnt_reg) + 9'h001 >= 9'(huntThr)) begin
                            hunt_reg     <= ATF_SEEK;
                            candIdx_reg  <= candIdx_reg + 2'h1;
                            huntCnt_reg  <= 8'h00;
                            matchCnt_reg <= 8'h00;
                        end else begin
                            huntCnt_reg <= huntCnt_reg + 8'h01;
                        end
                        if (!isSync) begin
                            hunt_reg     <= ATF_SEEK;
                            matchCnt_reg <= 8'h00;
                        end else if (9'(matchCnt_reg) + 9'h001 > 9'(lockThr)) begin
                            hunt_reg    <= ATF_LOCKED;
                            candIdx_reg <= candIdx_reg;
                            errCnt_reg  <= 8'h00;
                            huntCnt_reg <= 8'h00;
                        end else begin
                            matchCnt_reg <= matchCnt_reg + 8'h01;
                        end
                    end
                end
                ATF_LOCKED: begin
                    if (atBound) begin
                        pos_reg <= 8'h01;
                        if (isSync) begin
                            errCnt_reg <= 8'h00;
                        end else if (9'(errCnt_reg) + 9'h001 > 9'(unlockThr)) begin
                            hunt_reg     <= ATF_SEEK;
                            candIdx_reg  <= 2'h0;
                            matchCnt_reg <= 8'h00;
                            errCnt_reg   <= 8'h00;
                            huntCnt_reg  <= 8'h00;
                        end else begin
                            errCnt_reg <= errCnt_reg + 8'h01;
                        end
                    end
                end
                default: begin
                    hunt_reg <= ATF_SEEK;
                end
            endcase
        end
    end

    // words seen since the last sync-valued byte, for length checks
    always_ff @(posedge core_clk) begin
        if (rst) begin
            since_reg <= 9'h000;
            rxRunt    <= 1'b0;
            rxGiant   <= 1'b0;
        end else begin
            rxRunt  <= 1'b0;
            rxGiant <= 1'b0;
            if (rxRdValid) begin
                if (isSync) begin
                    since_reg <= 9'h001;
                    if (hunt_reg == ATF_LOCKED && since_reg != 9'h000) begin
                        rxRunt  <= (since_reg < 9'(curSize));
                        rxGiant <= (since_reg > 9'(curSize));
                    end
                end else if (since_reg != 9'h1ff) begin
                    since_reg <= since_reg + 9'h001;
                end
            end
        end
    end

    // user side output registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxDout     <= 8'h00;
            rxDvalid   <= 1'b0;
            rxPsync    <= 1'b0;
            rxFifoFull <= 1'b0;
            rxStatus   <= '0;
        end else begin
            rxFifoFull <= rxFull;
            // valid low when nothing was read
            rxDvalid   <= rxRdValid;
            rxDout     <= rxRdData;
            // start pulse on a locked sync at its place
            rxPsync    <= rxRdValid && (hunt_reg == ATF_LOCKED) && atBound && isSync;
            rxStatus   <= '{locked:   (hunt_reg == ATF_LOCKED),
                            syncByte: curSync,
                            pktSize:  curSize};
        end
    end
endmodule : asi_transport_framer
`default_nettype wire

// file: atf_checker.sv
// concurrent checks on the transport framer ports
`timescale 1ns/10ps
`default_nettype none
module atf_checker
    import atf_pkg::*;
#(
    parameter int TX_AW = 4,
    parameter int RX_AW = 4
) (
    input wire logic           core_clk,
    input wire logic           rst,
    input wire logic           txPsync,
    input wire logic           txDvalid,
    input wire atf_sym_t       txWord,
    input wire logic           txFifoFull,
    input wire atf_sym_t       rxWord,
    input wire logic [7:0]     rxDout,
    input wire logic           rxDvalid,
    input wire logic           rxPsync,
    input wire atf_rx_status_t rxStatus,
    input wire logic           rxRunt,
    input wire logic           rxGiant
);
    localparam int TX_LIM = 3 * (2 ** TX_AW) + 8;
    localparam int RX_LIM = (2 ** RX_AW) + 6;
    logic [9:0] txIdle_reg;
    logic [9:0] rxIdle_reg;
    logic [7:0] first_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // cycles since the last valid input word
    always_ff @(posedge core_clk) begin
        if (rst || txDvalid) txIdle_reg <= '0;
        else if (txIdle_reg != '1) txIdle_reg <= txIdle_reg + 10'h1;
    end
    // cycles since the last received data word, and the first data word after an idle gap of RX_LIM cycles
    always_ff @(posedge core_clk) begin
        if (rst || !rxWord.k) rxIdle_reg <= '0;
        else if (rxIdle_reg != '1) rxIdle_reg <= rxIdle_reg + 10'h1;
        if (!rxWord.k && rxIdle_reg >= RX_LIM) first_reg <= rxWord.data;
    end
    sequence txStart;
        txDvalid && txPsync && !txFifoFull && txIdle_reg >= TX_LIM;
    endsequence
    sequence twoCommas;
        txWord.k ##1 txWord.k;
    endsequence
    sequence rxFirst;
        !rxWord.k && rxIdle_reg >= RX_LIM;
    endsequence
    AST_RESET_CLEAR: assert property (disable iff (1'b0) $past(rst) |-> txWord.k
        && !txFifoFull && !rxDvalid && !rxPsync && !rxRunt && !rxGiant)
        else $error("output not cleared by reset");
    AST_TX_TWIN: assert property (txStart |-> ##[3:6] (twoCommas ##1 !txWord.k))
        else $error("start word not led by two commas");
    AST_TX_FILL: assert property (txIdle_reg >= TX_LIM |->
        txWord.k && txWord.data == 8'hbc)
        else $error("idle output is not a comma");
    AST_TX_FULL: assert property ($rose(txFifoFull) |->
        $past(txDvalid) || $past(txDvalid, 2) || $past(txDvalid, 3))
        else $error("full flag without writes");
    AST_RX_PATH: assert property (rxFirst |=> ##[1:3] (rxDvalid && rxDout == first_reg))
        else $error("received byte not delivered");
    AST_PSYNC: assert property (rxPsync |->
        rxDvalid && rxStatus.locked && rxDout == rxStatus.syncByte)
        else $error("start pulse not on a sync byte");
    AST_STATUS_HOLD: assert property (rxStatus.locked && $past(rxStatus.locked) |->
        $stable(rxStatus))
        else $error("status moved while locked");
    AST_FLAG_ON_SYNC: assert property (rxRunt || rxGiant |->
        !(rxRunt && rxGiant) && rxDvalid && rxDout == rxStatus.syncByte)
        else $error("length flag not on a sync byte");
endmodule : atf_checker
bind asi_transport_framer atf_checker #(.TX_AW(TX_AW), .RX_AW(RX_AW)) chk (
    .core_clk(core_clk), .rst(rst), .txPsync(txPsync), .txDvalid(txDvalid),
    .txWord(txWord), .txFifoFull(txFifoFull), .rxWord(rxWord), .rxDout(rxDout),
    .rxDvalid(rxDvalid), .rxPsync(rxPsync), .rxStatus(rxStatus), .rxRunt(rxRunt),
    .rxGiant(rxGiant)
);
`default_nettype wire

// file: atf_xcvr_model.sv
// transceiver model: loops every transmitted symbol back one cycle later
`timescale 1ns/10ps
`default_nettype none
module atf_xcvr_model
    import atf_pkg::*;
(
    input  wire logic     core_clk,
    input  wire atf_sym_t txWord,
    output var  atf_sym_t rxWord
);
    always_ff @(posedge core_clk) begin
        rxWord <= txWord;
    end
endmodule : atf_xcvr_model
`default_nettype wire

// file: asi_transport_framer_tb.sv
// loopback bench: packets through transmitter, transceiver model and receiver
`timescale 1ns/10ps
`default_nettype none
module asi_transport_framer_tb
    import atf_pkg::*;
();
    logic           core_clk;
    logic           rst;
    logic [7:0]     txDin;
    logic           txPsync;
    logic           txDvalid;
    atf_sym_t       txWord;
    logic           txFifoFull;
    atf_sym_t       rxWord;
    logic [7:0]     rxDout;
    logic           rxDvalid;
    logic           rxPsync;
    logic           rxFifoFull;
    logic [7:0]     lockThr;
    logic [7:0]     unlockThr;
    logic [7:0]     huntThr;
    atf_rx_status_t rxStatus;
    logic           rxRunt;
    logic           rxGiant;
    logic [7:0]     byteQ[$];
    logic [1:0]     evQ[$];
    int             error_cnt;
    int             total_checks;
    bit             track;
    bit             fullSeen;

    asi_transport_framer #(.TX_AW(4), .RX_AW(4)) dut (
        .core_clk(core_clk), .rst(rst), .txDin(txDin), .txPsync(txPsync),
        .txDvalid(txDvalid), .txWord(txWord), .txFifoFull(txFifoFull), .rxWord(rxWord),
        .rxDout(rxDout), .rxDvalid(rxDvalid), .rxPsync(rxPsync), .rxFifoFull(rxFifoFull),
        .lockThr(lockThr), .unlockThr(unlockThr), .huntThr(huntThr), .rxStatus(rxStatus),
        .rxRunt(rxRunt), .rxGiant(rxGiant)
    );
    atf_xcvr_model xcvr (.core_clk(core_clk), .txWord(txWord), .rxWord(rxWord));

    // clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // compare and count
    task automatic cmp_val(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    // one byte in, then idle cycles with decoy data and start flag
    task automatic put(input logic [7:0] b, input logic ps);
        txDin <= b;
        txPsync <= ps;
        txDvalid <= 1'b1;
        byteQ.push_back(b);
        @(posedge core_clk);
        txDin <= 8'h47;
        txPsync <= 1'b1;
        txDvalid <= 1'b0;
        // gaps keep the word rate under the comma overhead
        repeat (1 + $urandom_range(1)) @(posedge core_clk);
    endtask : put

    task automatic pkt(input logic [7:0] s, input int len, input int alt, input logic ps);
        put(s, ps);
        for (int i = 1; i < len; i++) put(i == alt ? 8'h47 : 8'($urandom) & 8'h3f, 1'b0);
    endtask : pkt

    // wait for the loopback to deliver every noted byte
    task automatic drain(input string name);
        for (int i = 0; i < 600 && byteQ.size() != 0; i++) @(posedge core_clk);
        cmp_val(17'(byteQ.size()), 17'h0);
        cmp_val({16'h0, rxFifoFull}, 17'h0);
        $display("test %s done", name);
    endtask : drain

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // take the oldest note off the queue for each delivered byte or flag
    always @(posedge core_clk) begin
        if (track && rxDvalid)
            cmp_val({9'h0, rxDout}, byteQ.size() ? {9'h0, byteQ.pop_front()} : 'x);
        if (track && (rxRunt || rxGiant))
            cmp_val({rxGiant, rxRunt}, evQ.size() ? {15'h0, evQ.pop_front()} : 'x);
        if (txFifoFull === 1'b1) fullSeen = 1'b1;
    end

    // watchdog
    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h68db810b));
        {rst, txDin, txPsync, txDvalid} = {1'b1, 10'h0};
        {lockThr, unlockThr, huntThr} = {8'h2, 8'h3, 8'h4};
        {track, fullSeen, error_cnt, total_checks} = {1'b1, 1'b0, 64'h0};
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (60) @(posedge core_clk);
        for (int i = 0; i < 6; i++) pkt(8'h47, 188, 0, 1'b1);
        drain("lock");
        cmp_val(rxStatus, {1'b1, 8'h47, 8'hbc});
        // short then long packet while locked
        evQ = '{2'h1, 2'h2};
        pkt(8'h47, 187, 0, 1'b1);
        pkt(8'h47, 189, 0, 1'b1);
        pkt(8'h47, 188, 0, 1'b1);
        pkt(8'h47, 188, 0, 1'b1);
        drain("runt giant");
        cmp_val(17'(evQ.size()), 17'h0);
        cmp_val(rxStatus, {1'b1, 8'h47, 8'hbc});
        // sync-free data drops lock
        for (int i = 0; i < 5; i++) pkt(8'h11, 188, 0, 1'b0);
        drain("unlock");
        cmp_val(rxStatus, {1'b0, 8'h47, 8'hbc});
        // hunt moves on to the last candidate
        for (int i = 0; i < 21; i++) pkt(8'hb8, 204, i[0] ? 5 : 9, 1'b1);
        drain("hunt");
        cmp_val(rxStatus, {1'b1, 8'hb8, 8'hcc});
        // burst fills the transmit side, then reset
        track = 1'b0;
        txDvalid <= 1'b1;
        repeat (48) @(posedge core_clk);
        txDvalid <= 1'b0;
        rst <= 1'b1;
        cmp_val({16'h0, fullSeen}, 17'h1);
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        cmp_val({txFifoFull, txWord, rxStatus.syncByte}, {1'b0, 9'h1bc, 8'h47});
        drain("full reset");
        print_verdict();
    end
endmodule : asi_transport_framer_tb
`default_nettype wire
